// file: hw/uam_consts.vh
// Constants for the network-addressable UART extension block
`ifndef UAM_CONSTS_VH
`define UAM_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UAM_OFS_MODEM_CONTROL     8'h00
`define UAM_OFS_MODEM_STATUS      8'h04
`define UAM_OFS_FRAC_DIVISOR      8'h08
`define UAM_OFS_NET_CONTROL       8'h0c
`define UAM_OFS_NET_IRQ_ID        8'h10
`define UAM_OFS_NODE_ADDRESS      8'h14
`define UAM_OFS_BASE_IRQ_ENABLE   8'h18

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UAM_RST_MODEM_CONTROL     8'h00
`define UAM_RST_FRAC_DIVISOR      16'h0000
`define UAM_RST_NET_CONTROL       8'h00
`define UAM_RST_NODE_ADDRESS      8'h00
`define UAM_RST_BASE_IRQ_ENABLE   4'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UAM_MC_LOOPBACK           4
`define UAM_MC_USER_OUTPUT_TWO               3
`define UAM_MC_USER_OUTPUT_ONE               2
`define UAM_MC_RTS                1
`define UAM_MC_DTR                0
`define UAM_FD_ENABLE             15
`define UAM_FD_MULT_HI            12
`define UAM_FD_MULT_LO            11
`define UAM_FD_NUM_HI             10
`define UAM_NC_MODE               7
`define UAM_NC_TX9                6
`define UAM_NC_RX9                5
`define UAM_NC_IRQ_EN             4
`define UAM_NC_DATA9              3
`define UAM_NC_DRIVER             2
`define UAM_NC_POLARITY           1
`define UAM_NC_MARKER             0
`define UAM_IE_RX_FULL            0
`define UAM_IE_MODEM              3

// ----------------------------------------------------------------------
// Interrupt identifier codes, bits 3:1; UAM_ID_NONE is the full 4-bit value
// ----------------------------------------------------------------------
`define UAM_ID_LINE_STATUS        3'h3
`define UAM_ID_ADDR_MATCH         3'h6
`define UAM_ID_RX_FULL            3'h2
`define UAM_ID_ADDR_SENT          3'h5
`define UAM_ID_TX_EMPTY           3'h1
`define UAM_ID_MODEM              3'h0
`define UAM_ID_NONE               4'h1

// Multiplier value used when the stored field reads zero
`define UAM_MULT_ZERO_MEANS       3'h4

`endif

// file: hw/uam_net_uart.v
// Modem control, modem status, fractional divider fields and network mode of a UART
`timescale 1ns/100ps
`include "uam_consts.vh"

module uam_net_uart (
   input  wire        core_clk,
   input  wire        reset_n,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Modem pins, active low
   input  wire        ctsPin_n,
   input  wire        dsrPin_n,
   input  wire        dcdPin_n,
   input  wire        ringPin_n,
   output reg         rtsPin_n,
   output reg         dtrPin_n,
   // Serial line
   input  wire        txShiftOut,
   output reg         serialOut,
   output reg         serialOutEn_n,
   // Base transmitter and receiver, same clock
   input  wire        txHoldingWrite,
   input  wire        txWordDone,
   input  wire        txBufferEmpty,
   input  wire        rxWordValid,
   input  wire [7:0]  rxWord,
   input  wire        rxMarker,
   input  wire        rxHoldingRead,
   input  wire        baseIdRead,
   input  wire        lineStatusPending,
   input  wire        rxFullPending,
   input  wire        txEmptyPending,
   // Configuration towards the base core
   output reg         fractionalEnable,
   output reg  [2:0]  fractionalMultiplier,
   output reg  [10:0] fractionalNumerator,
   output reg         parityDisable,
   output reg         txMarkerBit,
   output reg         ninthBitTx,
   output reg         ninthBitRx,
   output reg         nineBitData,
   output reg         networkIrq
);

   // -------------------------------------------------------------------
   // Registers and state
   // -------------------------------------------------------------------
   reg  [7:0]  modemControl;
   reg  [15:0] fractionalDivisor;
   reg  [7:0]  networkControl;
   reg  [7:0]  nodeAddress;
   reg  [3:0]  baseIrqEnable;
   reg  [3:0]  changeFlags;
   reg         matchFlag;
   reg         addrSentFlag;
   reg         addrInFlight;
   reg  [3:0]  syncA;
   reg  [3:0]  syncB;
   reg  [3:0]  lastLevels;
   reg         busPending;
   reg         busWrite;
   reg  [7:0]  busAddr;

   wire        loopback;
   wire        netMode;
   wire [3:0]  levels;
   wire [3:0]  nextFlags;
   wire        addressWord;
   wire        matchEvent;
   wire        addrSentEvent;
   wire        modemPending;
   wire        takeReq;
   wire        rdModemStatus;
   wire        driveLine;
   wire [3:0]  idCode;
   reg  [3:0]  next_id;

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------
   function [31:0] regRead;
      input [7:0] addr;
      input [3:0] idv;
      begin
         if (addr == `UAM_OFS_MODEM_CONTROL) begin
            regRead = {24'h000000, modemControl};
         end else if (addr == `UAM_OFS_MODEM_STATUS) begin
            regRead = {24'h000000, levels, changeFlags};
         end else if (addr == `UAM_OFS_FRAC_DIVISOR) begin
            regRead = {16'h0000, fractionalDivisor};
         end else if (addr == `UAM_OFS_NET_CONTROL) begin
            regRead = {24'h000000, networkControl};
         end else if (addr == `UAM_OFS_NET_IRQ_ID) begin
            regRead = {28'h0000000, idv};
         end else if (addr == `UAM_OFS_NODE_ADDRESS) begin
            regRead = {24'h000000, nodeAddress};
         end else if (addr == `UAM_OFS_BASE_IRQ_ENABLE) begin
            regRead = {28'h0000000, baseIrqEnable};
         end else begin
            regRead = 32'h00000000;
         end
      end
   endfunction

   // -------------------------------------------------------------------
   // Modem inputs
   // -------------------------------------------------------------------
   // Pins pass two flops; order is {carrier, ring, set-ready, clear-to-send}
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= 4'h0;
         syncB <= 4'h0;
      end else begin
         syncA <= {~dcdPin_n, ~ringPin_n, ~dsrPin_n, ~ctsPin_n};
         syncB <= syncA;
      end
   end

   assign loopback = modemControl[`UAM_MC_LOOPBACK];
   // In loopback the pins are ignored and the control outputs feed back
   assign levels = loopback ?
      {modemControl[`UAM_MC_USER_OUTPUT_TWO], modemControl[`UAM_MC_USER_OUTPUT_ONE],
       modemControl[`UAM_MC_DTR], modemControl[`UAM_MC_RTS]} : syncB;

   // Ring flag catches the inverted ring line falling, which is the trailing edge
   assign nextFlags[3] = levels[3] ^ lastLevels[3];
   assign nextFlags[2] = ~levels[2] & lastLevels[2];
   assign nextFlags[1] = levels[1] ^ lastLevels[1];
   assign nextFlags[0] = levels[0] ^ lastLevels[0];

   // -------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------
   // Every transfer takes one wait state, so a write always lands before the
   // next read samples the registers.
   assign takeReq = hsel & htrans[1] & hready;
   assign rdModemStatus = busPending & ~busWrite &
                          (busAddr == `UAM_OFS_MODEM_STATUS);

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         busPending <= 1'b0;
         busWrite   <= 1'b0;
         busAddr    <= 8'h00;
         hreadyout  <= 1'b1;
         hrdata     <= 32'h00000000;
         hresp      <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (busPending) begin
            busPending <= 1'b0;
            hreadyout  <= 1'b1;
            if (!busWrite) begin
               hrdata <= regRead(busAddr, idCode);
            end
         end else if (takeReq) begin
            busPending <= 1'b1;
            busWrite   <= hwrite;
            busAddr    <= {haddr[7:2], 2'b00};
            hreadyout  <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Software-written registers
   // -------------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         modemControl      <= `UAM_RST_MODEM_CONTROL;
         fractionalDivisor <= `UAM_RST_FRAC_DIVISOR;
         networkControl    <= `UAM_RST_NET_CONTROL;
         nodeAddress       <= `UAM_RST_NODE_ADDRESS;
         baseIrqEnable     <= `UAM_RST_BASE_IRQ_ENABLE;
      end else if (busPending && busWrite) begin
         if (busAddr == `UAM_OFS_MODEM_CONTROL) begin
            modemControl <= {3'b000, hwdata[4:0]};
         end else if (busAddr == `UAM_OFS_FRAC_DIVISOR) begin
            fractionalDivisor <= {hwdata[15], 2'b00, hwdata[12:0]};
         end else if (busAddr == `UAM_OFS_NET_CONTROL) begin
            networkControl <= hwdata[7:0];
         end else if (busAddr == `UAM_OFS_NODE_ADDRESS) begin
            nodeAddress <= hwdata[7:0];
         end else if (busAddr == `UAM_OFS_BASE_IRQ_ENABLE) begin
            baseIrqEnable <= hwdata[3:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Sticky flags
   // -------------------------------------------------------------------
   assign netMode = networkControl[`UAM_NC_MODE];
   // Polarity bit chooses which marker value flags an address word
   assign addressWord = rxMarker ^ networkControl[`UAM_NC_POLARITY];
   assign matchEvent = rxWordValid & netMode & networkControl[`UAM_NC_RX9] &
                       addressWord & (rxWord == nodeAddress);
   assign addrSentEvent = txWordDone & addrInFlight & txBufferEmpty;

   // A change arriving in the cycle of the clearing read still sets the flag
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lastLevels   <= 4'h0;
         changeFlags  <= 4'h0;
         matchFlag    <= 1'b0;
         addrSentFlag <= 1'b0;
         addrInFlight <= 1'b0;
      end else begin
         lastLevels <= levels;
         if (rdModemStatus) begin
            changeFlags <= nextFlags;
         end else begin
            changeFlags <= changeFlags | nextFlags;
         end
         if (matchEvent) begin
            matchFlag <= 1'b1;
         end else if (rxHoldingRead) begin
            matchFlag <= 1'b0;
         end
         if (txHoldingWrite) begin
            addrInFlight <= netMode & ninthBitTx &
                            networkControl[`UAM_NC_MARKER];
         end
         if (addrSentEvent) begin
            addrSentFlag <= 1'b1;
         end else if (txHoldingWrite || baseIdRead) begin
            addrSentFlag <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Interrupt identifier
   // -------------------------------------------------------------------
   assign modemPending = |changeFlags & baseIrqEnable[`UAM_IE_MODEM];

   always @* begin
      if (lineStatusPending) begin
         next_id = {`UAM_ID_LINE_STATUS, 1'b0};
      end else if (matchFlag && baseIrqEnable[`UAM_IE_RX_FULL]) begin
         next_id = {`UAM_ID_ADDR_MATCH, 1'b0};
      end else if (rxFullPending) begin
         next_id = {`UAM_ID_RX_FULL, 1'b0};
      end else if (addrSentFlag) begin
         next_id = {`UAM_ID_ADDR_SENT, 1'b0};
      end else if (txEmptyPending) begin
         next_id = {`UAM_ID_TX_EMPTY, 1'b0};
      end else if (modemPending) begin
         next_id = {`UAM_ID_MODEM, 1'b0};
      end else begin
         next_id = `UAM_ID_NONE;
      end
   end
   assign idCode = next_id;

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Outside network mode the line is always driven; single-master use
   // relies on software setting the driver bit as well.
   assign driveLine = ~netMode | networkControl[`UAM_NC_DRIVER];

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rtsPin_n             <= 1'b1;
         dtrPin_n             <= 1'b1;
         serialOut            <= 1'b1;
         serialOutEn_n        <= 1'b1;
         fractionalEnable     <= 1'b0;
         fractionalMultiplier <= `UAM_MULT_ZERO_MEANS;
         fractionalNumerator  <= 11'h000;
         parityDisable        <= 1'b0;
         txMarkerBit          <= 1'b0;
         ninthBitTx           <= 1'b0;
         ninthBitRx           <= 1'b0;
         nineBitData          <= 1'b0;
         networkIrq           <= 1'b0;
      end else begin
         // Loopback keeps the pins quiet by holding them inactive
         rtsPin_n <= ~modemControl[`UAM_MC_RTS] | loopback;
         dtrPin_n <= ~modemControl[`UAM_MC_DTR] | loopback;
         serialOut <= txShiftOut | loopback;
         serialOutEn_n <= ~driveLine;
         fractionalEnable <= fractionalDivisor[`UAM_FD_ENABLE];
         if (fractionalDivisor[`UAM_FD_MULT_HI:`UAM_FD_MULT_LO] == 2'b00) begin
            fractionalMultiplier <= `UAM_MULT_ZERO_MEANS;
         end else begin
            fractionalMultiplier <=
               {1'b0, fractionalDivisor[`UAM_FD_MULT_HI:`UAM_FD_MULT_LO]};
         end
         fractionalNumerator <= fractionalDivisor[`UAM_FD_NUM_HI:0];
         parityDisable <= netMode;
         txMarkerBit <= netMode & networkControl[`UAM_NC_MARKER];
         ninthBitTx <= netMode & networkControl[`UAM_NC_TX9];
         ninthBitRx <= netMode & networkControl[`UAM_NC_RX9];
         nineBitData <= netMode & networkControl[`UAM_NC_DATA9] &
                        ~networkControl[`UAM_NC_TX9];
         networkIrq <= netMode & networkControl[`UAM_NC_IRQ_EN] &
                       ~next_id[0];
      end
   end

endmodule

// file: verif/uam_net_uart_checker.sv
// Assertion checker for the network UART extension block
`timescale 1ns/100ps
module uam_net_uart_checker (
   input wire       core_clk,
   input wire       reset_n,
   input wire       hsel,
   input wire [1:0] htrans,
   input wire       hready,
   input wire       hreadyout,
   input wire       hresp,
   input wire       txShiftOut,
   input wire       serialOut,
   input wire       serialOutEn_n,
   input wire       rtsPin_n,
   input wire       dtrPin_n,
   input wire [2:0] fractionalMultiplier,
   input wire       parityDisable,
   input wire       txMarkerBit,
   input wire       ninthBitTx,
   input wire       ninthBitRx,
   input wire       networkIrq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   okay_resp_a: assert property (!hresp)
      else $error("bus response not okay");
   one_wait_a: assert property (hsel && htrans[1] && hready && hreadyout
      |=> !hreadyout ##1 hreadyout) else $error("transfer not one wait state");
   serial_src_a: assert property (!serialOut |-> !$past(txShiftOut))
      else $error("serial output low without a low source bit");
   loop_pins_a: assert property (serialOut && !$past(txShiftOut)
      |-> rtsPin_n && dtrPin_n) else $error("control pins active in loopback");
   irq_mode_a: assert property (networkIrq |-> parityDisable)
      else $error("network interrupt outside network mode");
   tx9_mode_a: assert property (ninthBitTx |-> parityDisable)
      else $error("ninth bit transmit outside network mode");
   rx9_mode_a: assert property (ninthBitRx |-> parityDisable)
      else $error("ninth bit receive outside network mode");
   marker_mode_a: assert property (txMarkerBit |-> parityDisable)
      else $error("marker bit outside network mode");
   driver_on_a: assert property (!parityDisable && $past(reset_n) |-> !serialOutEn_n)
      else $error("serial output released in ordinary mode");
   mult_range_a: assert property (fractionalMultiplier inside {[1:4]})
      else $error("fractional multiplier out of range");
endmodule

bind uam_net_uart uam_net_uart_checker uam_net_uart_checker_inst (.core_clk, .reset_n,
   .hsel, .htrans, .hready, .hreadyout, .hresp, .txShiftOut, .serialOut, .serialOutEn_n,
   .rtsPin_n, .dtrPin_n, .fractionalMultiplier, .parityDisable, .txMarkerBit,
   .ninthBitTx, .ninthBitRx, .networkIrq);

// file: verif/uam_remote_node.sv
// Remote network node and modem line model facing the block
`timescale 1ns/100ps
module uam_remote_node (
   input  wire       core_clk,
   output reg        ctsPin_n,
   output reg        dsrPin_n,
   output reg        dcdPin_n,
   output reg        ringPin_n,
   output reg        rxWordValid,
   output reg  [7:0] rxWord,
   output reg        rxMarker
);
   // Modem lines have pull-ups, so idle lines rest high
   initial begin
      {dcdPin_n, ringPin_n, dsrPin_n, ctsPin_n} = 4'hf;
      rxWordValid = 1'b0;
      rxWord = 8'h00;
      rxMarker = 1'b0;
   end
   // Argument is {carrier, ring, set-ready, clear-to-send}, 1 = asserted
   task set_lines(input [3:0] on);
      @(posedge core_clk);
      {dcdPin_n, ringPin_n, dsrPin_n, ctsPin_n} <= ~on;
   endtask
   // Word and ninth bit are junk outside the strobe so stale data cannot match
   task send_word(input [7:0] w, input m);
      @(posedge core_clk);
      rxWordValid <= 1'b1;
      rxWord <= w;
      rxMarker <= m;
      @(posedge core_clk);
      rxWordValid <= 1'b0;
      rxWord <= ~w;
      rxMarker <= ~m;
   endtask
endmodule

// file: verif/uam_net_uart_tb.sv
// Self-checking testbench for the network UART extension block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module uam_net_uart_tb;
   logic        core_clk, reset_n, hsel, hwrite, txShiftOut, txBufferEmpty;
   logic [7:0]  haddr, na;
   logic [1:0]  htrans;
   logic [31:0] hwdata, w;
   logic [3:0]  stb;
   logic [2:0]  pend;
   wire  [31:0] hrdata;
   wire  [7:0]  rxWord;
   wire  [2:0]  fractionalMultiplier;
   wire  [10:0] fractionalNumerator;
   wire         hready, hreadyout, hresp, ctsPin_n, dsrPin_n, dcdPin_n, ringPin_n;
   wire         rtsPin_n, dtrPin_n, serialOut, serialOutEn_n, txHoldingWrite, txWordDone;
   wire         rxWordValid, rxMarker, rxHoldingRead, baseIdRead, fractionalEnable;
   wire         parityDisable, txMarkerBit, ninthBitTx, ninthBitRx, nineBitData, networkIrq;
   logic [63:0] q[$];
   logic [63:0] ex;
   logic        rdPhase = 1'b0;
   integer      n_fail = 0, n_compared = 0, k, seed;
   logic [7:0]  ra[5] = '{8'h00, 8'h08, 8'h0c, 8'h14, 8'h18};
   logic [31:0] rm[5] = '{32'h1f, 32'h9fff, 32'hff, 32'hff, 32'h0f};
   logic [7:0]  nv[7] = '{8'h00, 8'hc0, 8'h40, 8'ha4, 8'h20, 8'h88, 8'h85};
   logic [5:0]  ne[7] = '{6'h00, 6'h31, 6'h00, 6'h28, 6'h00, 6'h25, 6'h22};
   wire         lineStatusPending, rxFullPending, txEmptyPending;
   assign hready = hreadyout;
   assign {txHoldingWrite, txWordDone, rxHoldingRead, baseIdRead} = stb;
   assign {lineStatusPending, rxFullPending, txEmptyPending} = pend;
   uam_net_uart uam_net_uart_inst (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ctsPin_n, .dsrPin_n,
      .dcdPin_n, .ringPin_n, .rtsPin_n, .dtrPin_n, .txShiftOut, .serialOut, .serialOutEn_n,
      .txHoldingWrite, .txWordDone, .txBufferEmpty, .rxWordValid, .rxWord, .rxMarker,
      .rxHoldingRead, .baseIdRead, .lineStatusPending, .rxFullPending, .txEmptyPending,
      .fractionalEnable, .fractionalMultiplier, .fractionalNumerator, .parityDisable,
      .txMarkerBit, .ninthBitTx, .ninthBitRx, .nineBitData, .networkIrq);
   uam_remote_node uam_remote_node_inst (.core_clk, .ctsPin_n, .dsrPin_n, .dcdPin_n,
      .ringPin_n, .rxWordValid, .rxWord, .rxMarker);
   always #12.5 core_clk = ~core_clk;
   // -------------------------------------------------------------------
   // Bus tasks
   // -------------------------------------------------------------------
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded wait, a hung slave ends the run as a mismatch
   task wait_rdy;
      integer i;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1) begin
         n_fail++;
         wrap_up;
      end
   endtask
   task xfer(input [7:0] a, input wr, input [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rd(input [7:0] a, input [31:0] e, input [31:0] m);
      q.push_back({m, e & m});
      xfer(a, 1'b0, 32'h0);
   endtask
   task settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task pulse(input [3:0] s);
      @(posedge core_clk) stb <= s;
      @(posedge core_clk) stb <= 4'h0;
   endtask
   // Read data is judged at the edge that ends the data phase
   always @(posedge core_clk) begin
      if (rdPhase && hreadyout) begin
         ex = q.pop_front();
         `CHK("hrdata", ex[31:0], hrdata & ex[63:32])
      end
      if (hreadyout) rdPhase = hsel && htrans[1] && !hwrite;
   end
   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   initial begin
      seed = $urandom(55579);
      {core_clk, reset_n, hsel, hwrite, haddr, htrans, hwdata} = '0;
      {stb, pend, txShiftOut, txBufferEmpty} = 9'h3;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      for (k = 0; k < 5; k++) rd(ra[k], 32'h0, 32'hffffffff);
      rd(8'h10, 32'h1, 32'hffffffff);
      rd(8'h04, 32'h0, 32'h0);
      rd(8'h04, 32'h0, 32'hff);
      for (k = 0; k < 5; k++) begin
         w = $urandom;
         wr(ra[k], w);
         rd(ra[k], w & rm[k], 32'hffffffff);
         wr(ra[k], 32'h0);
      end
      wr(8'h1c, 32'hffffffff);
      rd(8'h1c, 32'h0, 32'hffffffff);
      wr(8'h10, 32'h0e);
      rd(8'h10, 32'h1, 32'hffffffff);
      for (k = 0; k < 4; k++) begin
         wr(8'h00, k);
         settle;
         `CHK("rtsPin_n", ~k[1], rtsPin_n)
         `CHK("dtrPin_n", ~k[0], dtrPin_n)
      end
      wr(8'h00, 32'h1f);
      @(posedge core_clk) txShiftOut <= 1'b0;
      settle;
      `CHK("loopPins", 3'h7, {serialOut, rtsPin_n, dtrPin_n})
      rd(8'h04, 32'hf0, 32'hf0);
      wr(8'h00, 32'h10);
      rd(8'h04, 32'h0, 32'hf0);
      wr(8'h00, 32'h0);
      settle;
      `CHK("serialOut", 1'b0, serialOut)
      @(posedge core_clk) txShiftOut <= 1'b1;
      rd(8'h04, 32'h0, 32'h0);
      wr(8'h18, 32'h08);
      uam_remote_node_inst.set_lines(4'h1);
      repeat (5) @(posedge core_clk);
      rd(8'h10, 32'h0, 32'hff);
      rd(8'h04, 32'h11, 32'hff);
      rd(8'h04, 32'h10, 32'hff);
      uam_remote_node_inst.set_lines(4'hf);
      repeat (5) @(posedge core_clk);
      rd(8'h04, 32'hfa, 32'hff);
      uam_remote_node_inst.set_lines(4'h0);
      repeat (5) @(posedge core_clk);
      rd(8'h04, 32'h0f, 32'hff);
      rd(8'h10, 32'h1, 32'hff);
      for (k = 0; k < 4; k++) begin
         w = $urandom;
         wr(8'h08, {16'h0, 1'b1, 2'b00, k[1:0], w[10:0]});
         settle;
         `CHK("fractionalEnable", 1'b1, fractionalEnable)
         `CHK("fractionalMultiplier", (k == 0) ? 3'h4 : k[2:0], fractionalMultiplier)
         `CHK("fractionalNumerator", w[10:0], fractionalNumerator)
      end
      wr(8'h08, 32'h7fff);
      settle;
      `CHK("fractionalEnable", 1'b0, fractionalEnable)
      for (k = 0; k < 7; k++) begin
         wr(8'h0c, nv[k]);
         settle;
         `CHK("netOut", ne[k], {parityDisable, ninthBitTx, ninthBitRx, nineBitData, txMarkerBit, serialOutEn_n})
      end
      na = $urandom;
      wr(8'h14, na);
      wr(8'h18, 32'h1);
      wr(8'h0c, 32'hb4);
      uam_remote_node_inst.send_word(na ^ 8'h01, 1'b1);
      rd(8'h10, 32'h1, 32'hff);
      uam_remote_node_inst.send_word(na, 1'b0);
      rd(8'h10, 32'h1, 32'hff);
      uam_remote_node_inst.send_word(na, 1'b1);
      rd(8'h10, 32'h0c, 32'hff);
      `CHK("networkIrq", 1'b1, networkIrq)
      pulse(4'h2);
      rd(8'h10, 32'h1, 32'hff);
      `CHK("networkIrq", 1'b0, networkIrq)
      wr(8'h18, 32'h0);
      uam_remote_node_inst.send_word(na, 1'b1);
      rd(8'h10, 32'h1, 32'hff);
      pulse(4'h2);
      wr(8'h18, 32'h1);
      wr(8'h0c, 32'hb6);
      uam_remote_node_inst.send_word(na, 1'b0);
      rd(8'h10, 32'h0c, 32'hff);
      pulse(4'h2);
      wr(8'h0c, 32'hd1);
      pulse(4'h8);
      pulse(4'h4);
      rd(8'h10, 32'h0a, 32'hff);
      pulse(4'h1);
      rd(8'h10, 32'h1, 32'hff);
      pulse(4'h8);
      pulse(4'h4);
      pulse(4'h8);
      rd(8'h10, 32'h1, 32'hff);
      wr(8'h0c, 32'h90);
      for (k = 0; k < 4; k++) begin
         @(posedge core_clk) pend <= 3'h7 >> k;
         rd(8'h10, (k == 3) ? 32'h1 : 32'h6 - 2 * k, 32'hff);
         `CHK("networkIrq", k != 3, networkIrq)
      end
      repeat (4) @(posedge core_clk);
      wrap_up;
   end
endmodule
